// *** hdl/sysrst_pkg.sv ***
`default_nettype none
package sysrst_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADR_WDCTL = 8'h00;
  localparam logic [7:0] ADR_NMIEN = 8'h04;
  localparam logic [7:0] ADR_FLAGS = 8'h08;
  localparam logic [7:0] ADR_IRQEN = 8'h0C;
  localparam logic [7:0] ADR_STAT = 8'h10;
  // Control register bits
  localparam int W_NMI_FN = 0;
  localparam int W_EDGE = 1;
  localparam int W_INTERVAL = 2;
  localparam int W_SVS_POR = 3;
  // NMI enable and flag bits share positions
  localparam int F_PIN = 0;
  localparam int F_OSC = 1;
  localparam int F_FLASH = 2;
  localparam int F_WDT = 3;
  localparam logic [3:0] WDCTL_RST = 4'h0;
  localparam logic [2:0] NMIEN_RST = 3'h0;
  // ----------------------------------------
  // Vectors and priorities
  // ----------------------------------------
  localparam int NSRC = 14;
  localparam logic [15:0] VEC_BASE = 16'hFFE0;
  localparam logic [15:0] VEC_NMI = 16'hFFFC;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [3:0] PRI_NMI = 4'hE;
  localparam logic [3:0] PRI_WDT = 4'hA;
  // ----------------------------------------
  // Status word and sequence timing
  // ----------------------------------------
  localparam int SR_GIE = 3;
  localparam logic [15:0] SR_KEEP = 16'h0040;
  localparam logic [2:0] ST_PUSH_PC = 3'h1;
  localparam logic [2:0] ST_PUSH_SR = 3'h2;
  localparam logic [2:0] ST_CLR_FLAG = 3'h3;
  localparam logic [2:0] ST_CLR_SR = 3'h4;
  localparam logic [2:0] ST_LOAD_PC = 3'h5;
  localparam logic [2:0] RT_POP_SR = 3'h1;
  localparam logic [2:0] RT_POP_PC = 3'h3;
  localparam logic [2:0] RT_LAST = 3'h4;

  typedef enum logic [2:0] {
    M_RESET = 3'b000,
    M_BOOT = 3'b001,
    M_IDLE = 3'b010,
    M_ACCEPT = 3'b011,
    M_RETURN = 3'b100
  } mode_t;

  typedef struct packed {
    logic pin_m;
    logic pin_s;
    logic svs_m;
    logic svs_s;
    logic lvl;
    logic por;
    logic power_up_clear;
    logic [3:0] wdctl;
    logic [2:0] nmi_en;
    logic [3:0] flags;
    logic [NSRC-1:0] irq_en;
    logic [1:0] cause;
    logic ack;
    logic [31:0] rdata;
    mode_t mode;
    logic [2:0] step;
    logic [3:0] idx;
    logic is_nmi;
    logic [15:0] vector;
    logic [15:0] sr_wd;
  } state_t;
endpackage
`default_nettype wire

// *** hdl/system_reset_and_interrupt_logic.sv ***
// Our own choices: the Wishbone slave port and the address map.
`default_nettype none
module system_reset_and_interrupt_logic (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic rst_nmi_pin_i,
  input wire logic supply_supervisor_low_i,
  // Event sources
  input wire logic watchdog_expire_i,
  input wire logic watchdog_key_viol_i,
  input wire logic flash_key_viol_i,
  input wire logic osc_fault_i,
  input wire logic flash_violation_i,
  input wire logic [13:0] irq_req_i,
  // CPU core
  input wire logic instr_boundary_i,
  input wire logic return_from_interrupt_i,
  input wire logic [15:0] status_word_i,
  output logic por_o,
  output logic puc_o,
  output logic busy_o,
  output logic push_pc_o,
  output logic push_sr_o,
  output logic pop_sr_o,
  output logic pop_pc_o,
  output logic status_wr_o,
  output logic [15:0] status_wd_o,
  output logic pc_load_o,
  output logic [15:0] vector_o,
  output logic [13:0] irq_taken_o,
  // Clock system
  output logic lfxt_lf_force_o,
  output logic xt2_off_o
);
  // ----------------------------------------
  // Reset state
  // ----------------------------------------
  localparam sysrst_pkg::state_t RST_STATE = '{
    pin_m: 1'b1,
    pin_s: 1'b1,
    svs_m: 1'b0,
    svs_s: 1'b0,
    lvl: 1'b1,
    por: 1'b1,
    power_up_clear: 1'b1,
    wdctl: sysrst_pkg::WDCTL_RST,
    nmi_en: sysrst_pkg::NMIEN_RST,
    flags: 4'h0,
    irq_en: 14'h0000,
    cause: 2'h3,
    ack: 1'b0,
    rdata: 32'h0000_0000,
    mode: sysrst_pkg::M_RESET,
    step: 3'h0,
    idx: 4'h0,
    is_nmi: 1'b0,
    vector: sysrst_pkg::VEC_RESET,
    sr_wd: 16'h0000
  };

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  sysrst_pkg::state_t q;
  sysrst_pkg::state_t n;
  logic por;
  logic power_up_clear;
  logic lvl;
  logic pin_evt;
  logic wdt_int_evt;
  logic wr;
  logic global_irq_enable;
  logic nmi_req;
  logic [13:0] mreq;
  logic [3:0] top;
  logic [15:0] wmask;
  logic [15:0] wdat;
  logic acc;
  logic ret;
  logic boot;
  logic at_push_pc;
  logic at_push_sr;
  logic at_clr_flag;
  logic at_clr_sr;
  logic at_load_pc;
  logic at_pop_sr;
  logic at_pop_pc;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = q;
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    n.pin_m = rst_nmi_pin_i;
    n.pin_s = q.pin_m;
    n.svs_m = supply_supervisor_low_i;
    n.svs_s = q.svs_m;

    // ----------------------------------------
    // Reset and clear sources
    // ----------------------------------------
    por = (~q.pin_s & ~q.wdctl[sysrst_pkg::W_NMI_FN])
      | (q.svs_s & q.wdctl[sysrst_pkg::W_SVS_POR]);
    power_up_clear = por
      | (watchdog_expire_i & ~q.wdctl[sysrst_pkg::W_INTERVAL])
      | watchdog_key_viol_i
      | flash_key_viol_i;
    n.por = por;
    n.power_up_clear = power_up_clear;
    wdt_int_evt = watchdog_expire_i & q.wdctl[sysrst_pkg::W_INTERVAL];

    // ----------------------------------------
    // Pin edge detector
    // ----------------------------------------
    // Level seen through the edge select, tracked in every mode
    lvl = q.pin_s ^ q.wdctl[sysrst_pkg::W_EDGE];
    n.lvl = lvl;
    pin_evt = q.wdctl[sysrst_pkg::W_NMI_FN] & lvl & ~q.lvl;
    // ----------------------------------------
    // Request gating and priority
    // ----------------------------------------
    global_irq_enable = status_word_i[sysrst_pkg::SR_GIE];
    nmi_req = |(q.flags[2:0] & q.nmi_en);
    mreq = irq_req_i;
    mreq[sysrst_pkg::PRI_WDT] = irq_req_i[sysrst_pkg::PRI_WDT]
      | q.flags[sysrst_pkg::F_WDT];
    mreq = mreq & q.irq_en & {14{global_irq_enable}};

    // ----------------------------------------
    // Priority encoder
    // ----------------------------------------
    top = 4'h0;
    for (int i = 0; i < sysrst_pkg::NSRC; i++) begin
      if (mreq[i]) begin
        top = 4'(i);
      end
    end
    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    n.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
    wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wdat = wb_dat_i[15:0] & wmask;
    if (n.ack & ~wb_we_i) begin
      case (wb_adr_i)
        sysrst_pkg::ADR_WDCTL: begin
          n.rdata = {28'h0, q.wdctl};
        end
        sysrst_pkg::ADR_NMIEN: begin
          n.rdata = {29'h0, q.nmi_en};
        end
        sysrst_pkg::ADR_FLAGS: begin
          n.rdata = {28'h0, q.flags};
        end
        sysrst_pkg::ADR_IRQEN: begin
          n.rdata = {18'h0, q.irq_en};
        end
        sysrst_pkg::ADR_STAT: begin
          n.rdata = {21'h0,
            q.pin_s,
            nmi_req,
            q.mode != sysrst_pkg::M_IDLE,
            q.idx,
            2'h0,
            q.cause};
        end
        default: begin
          n.rdata = 32'h0000_0000;
        end
      endcase
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (wr) begin
      case (wb_adr_i)
        sysrst_pkg::ADR_WDCTL: begin
          n.wdctl = (q.wdctl & ~wmask[3:0]) | wdat[3:0];
        end
        sysrst_pkg::ADR_NMIEN: begin
          n.nmi_en = (q.nmi_en & ~wmask[2:0]) | wdat[2:0];
        end
        sysrst_pkg::ADR_FLAGS: begin
          n.flags = q.flags & ~wdat[3:0];
        end
        sysrst_pkg::ADR_IRQEN: begin
          n.irq_en = (q.irq_en & ~wmask[13:0]) | wdat[13:0];
        end
        sysrst_pkg::ADR_STAT: begin
          n.cause = q.cause & ~wdat[1:0];
        end
        default: begin
        end
      endcase
    end
    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    case (q.mode)
      sysrst_pkg::M_RESET: begin
        if (!power_up_clear) begin
          n.mode = sysrst_pkg::M_BOOT;
          n.vector = sysrst_pkg::VEC_RESET;
          n.sr_wd = 16'h0000;
        end
      end
      sysrst_pkg::M_BOOT: begin
        n.mode = sysrst_pkg::M_IDLE;
      end
      sysrst_pkg::M_IDLE: begin
        if (instr_boundary_i) begin
          if (return_from_interrupt_i) begin
            n.mode = sysrst_pkg::M_RETURN;
            n.step = 3'h0;
          end else if (nmi_req) begin
            n.mode = sysrst_pkg::M_ACCEPT;
            n.step = 3'h0;
            n.is_nmi = 1'b1;
            n.idx = sysrst_pkg::PRI_NMI;
            n.vector = sysrst_pkg::VEC_NMI;
            n.sr_wd = status_word_i & sysrst_pkg::SR_KEEP;
          end else if (|mreq) begin
            n.mode = sysrst_pkg::M_ACCEPT;
            n.step = 3'h0;
            n.is_nmi = 1'b0;
            n.idx = top;
            n.vector = sysrst_pkg::VEC_BASE + {11'h0, top, 1'b0};
            n.sr_wd = status_word_i & sysrst_pkg::SR_KEEP;
          end
        end
      end
      sysrst_pkg::M_ACCEPT: begin
        n.step = q.step + 3'h1;
        if (q.step == sysrst_pkg::ST_CLR_FLAG) begin
          if (q.is_nmi) begin
            n.nmi_en = 3'h0;
          end else if (q.idx == sysrst_pkg::PRI_WDT) begin
            n.flags[sysrst_pkg::F_WDT] = 1'b0;
          end
        end
        if (q.step == sysrst_pkg::ST_LOAD_PC) begin
          n.mode = sysrst_pkg::M_IDLE;
        end
      end
      sysrst_pkg::M_RETURN: begin
        n.step = q.step + 3'h1;
        if (q.step == sysrst_pkg::RT_LAST) begin
          n.mode = sysrst_pkg::M_IDLE;
        end
      end
      default: begin
        n.mode = sysrst_pkg::M_RESET;
      end
    endcase

    // ----------------------------------------
    // Flag and cause capture
    // ----------------------------------------
    // Events set after any clear, so a set in the clear cycle wins
    n.flags = n.flags | {wdt_int_evt, flash_violation_i,
      osc_fault_i, pin_evt};
    n.cause = n.cause | {power_up_clear, por};
    // ----------------------------------------
    // Reset effects take precedence
    // ----------------------------------------
    if (power_up_clear) begin
      n.wdctl[2:0] = sysrst_pkg::WDCTL_RST[2:0];
      n.nmi_en = sysrst_pkg::NMIEN_RST;
      n.irq_en = 14'h0000;
      n.mode = sysrst_pkg::M_RESET;
      n.step = 3'h0;
    end
    if (por) begin
      n.wdctl[sysrst_pkg::W_SVS_POR] = sysrst_pkg::WDCTL_RST[3];
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= RST_STATE;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign acc = q.mode == sysrst_pkg::M_ACCEPT;
  assign ret = q.mode == sysrst_pkg::M_RETURN;
  assign boot = q.mode == sysrst_pkg::M_BOOT;
  assign at_push_pc = acc & (q.step == sysrst_pkg::ST_PUSH_PC);
  assign at_push_sr = acc & (q.step == sysrst_pkg::ST_PUSH_SR);
  assign at_clr_flag = acc & (q.step == sysrst_pkg::ST_CLR_FLAG);
  assign at_clr_sr = acc & (q.step == sysrst_pkg::ST_CLR_SR);
  assign at_load_pc = acc & (q.step == sysrst_pkg::ST_LOAD_PC);
  assign at_pop_sr = ret & (q.step == sysrst_pkg::RT_POP_SR);
  assign at_pop_pc = ret & (q.step == sysrst_pkg::RT_POP_PC);

  // ----------------------------------------
  // Bus and reset outputs
  // ----------------------------------------
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign por_o = q.por;
  assign puc_o = q.power_up_clear;

  // ----------------------------------------
  // Clock system
  // ----------------------------------------
  assign lfxt_lf_force_o = q.power_up_clear;
  assign xt2_off_o = q.power_up_clear;

  // ----------------------------------------
  // Sequencer strobes
  // ----------------------------------------
  assign busy_o = q.mode != sysrst_pkg::M_IDLE;
  assign push_pc_o = at_push_pc;
  assign push_sr_o = at_push_sr;
  assign pop_sr_o = at_pop_sr;
  assign pop_pc_o = at_pop_pc;
  assign status_wr_o = boot | at_clr_sr;
  assign status_wd_o = q.sr_wd;
  assign pc_load_o = boot | at_load_pc;
  assign vector_o = q.vector;
  for (genvar g = 0; g < sysrst_pkg::NSRC; g++) begin : g_taken
    assign irq_taken_o[g] = at_clr_flag & ~q.is_nmi
      & (q.idx == 4'(g));
  end
endmodule
`default_nettype wire

// *** test/sysrst_properties.sv ***
`default_nettype none
module sysrst_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic return_from_interrupt_i,
  input wire logic por_o,
  input wire logic puc_o,
  input wire logic busy_o,
  input wire logic push_pc_o,
  input wire logic push_sr_o,
  input wire logic pop_sr_o,
  input wire logic pop_pc_o,
  input wire logic status_wr_o,
  input wire logic pc_load_o,
  input wire logic [15:0] vector_o,
  input wire logic [13:0] irq_taken_o,
  input wire logic lfxt_lf_force_o,
  input wire logic xt2_off_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_POR_CLEARS: assert property (por_o |-> puc_o)
    else $error("reset without clear");
  AST_ACCEPT: assert property ($rose(busy_o) && !$past(return_from_interrupt_i) && !puc_o
    |=> push_pc_o)
    else $error("no push after accept");
  AST_SIX_CYCLES: assert property (push_pc_o |-> busy_o [*5] ##1 !busy_o)
    else $error("latency wrong");
  AST_SEQ: assert property (push_pc_o |=> push_sr_o ##2 status_wr_o ##1 pc_load_o)
    else $error("sequence order wrong");
  AST_TAKEN: assert property (|irq_taken_o |-> $past(push_sr_o) && $onehot(irq_taken_o))
    else $error("taken pulse wrong");
  AST_RETURN: assert property (pop_sr_o |-> ##2 pop_pc_o ##2 !busy_o)
    else $error("return timing wrong");
  AST_VECTOR: assert property (pc_load_o |-> vector_o >= 16'hFFE0 && !vector_o[0])
    else $error("vector outside table");
  AST_OSC_FORCE: assert property ($rose(puc_o) |-> ##[0:1] lfxt_lf_force_o && xt2_off_o)
    else $error("oscillators not forced");
  cover property (pc_load_o && vector_o == 16'hFFFC);
  cover property (pop_pc_o);
  cover property (puc_o && !por_o);
endmodule
bind system_reset_and_interrupt_logic sysrst_properties chk (.*);
`default_nettype wire

// *** test/cpu_core_model.sv ***
`default_nettype none
module cpu_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic gie_i,
  input wire logic return_from_interrupt_req_i,
  // Design side
  input wire logic puc_i,
  input wire logic push_sr_i,
  input wire logic pop_sr_i,
  output logic boundary_o,
  output logic return_from_interrupt_o,
  output logic [15:0] status_word_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic in_isr_q;
  always_ff @(posedge clk_i) begin
    boundary_o <= !rst_i && !puc_i;
    return_from_interrupt_o <= return_from_interrupt_req_i;
    if (rst_i || puc_i || pop_sr_i) begin
      in_isr_q <= 1'b0;
    end else if (push_sr_i) begin
      in_isr_q <= 1'b1;
    end
  end
  // Clock bit set so its survival is visible
  assign status_word_o = {9'h000, 1'b1, 2'h0, gie_i && !in_isr_q, 3'h0};
endmodule
`default_nettype wire

// *** test/system_reset_and_interrupt_logic_tb.sv ***
`default_nettype none
module system_reset_and_interrupt_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rst_nmi_pin_i;
  logic supply_supervisor_low_i, instr_boundary_i, return_from_interrupt_i, global_irq_enable, return_from_interrupt_req;
  logic por_o, puc_o, busy_o, push_pc_o, push_sr_o, pop_sr_o, pop_pc_o;
  logic status_wr_o, pc_load_o, lfxt_lf_force_o, xt2_off_o, saw_por, saw_puc;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] status_word_i, status_wd_o, vector_o;
  logic [13:0] irq_req_i, irq_taken_o, last_taken;
  logic [2:0] pucsrc;
  logic [1:0] nsrc;
  wire logic watchdog_expire_i = pucsrc[0];
  wire logic watchdog_key_viol_i = pucsrc[1];
  wire logic flash_key_viol_i = pucsrc[2];
  wire logic osc_fault_i = nsrc[0];
  wire logic flash_violation_i = nsrc[1];
  int bad_count, comparisons, cycles;
  system_reset_and_interrupt_logic dut (.*);
  cpu_core_model cpu (.clk_i(clk_i), .rst_i(rst_i), .gie_i(global_irq_enable),
    .return_from_interrupt_req_i(return_from_interrupt_req), .puc_i(puc_o), .push_sr_i(push_sr_o),
    .pop_sr_i(pop_sr_o), .boundary_o(instr_boundary_i), .return_from_interrupt_o(return_from_interrupt_i),
    .status_word_o(status_word_i));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (por_o === 1'b1) saw_por <= 1'b1;
    if (puc_o === 1'b1) saw_puc <= 1'b1;
    if (|irq_taken_o) last_taken <= irq_taken_o;
    if (cycles == 6000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(negedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      n++;
      @(negedge clk_i);
    end
    q = wb_dat_o;
    chk(n < 50, 1);
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_load(input logic [15:0] v);
    int n;
    n = 0;
    while (pc_load_o !== 1'b1 && n < 40) begin
      n++;
      @(posedge clk_i);
    end
    chk(n < 40 ? 32'(vector_o) : 32'h0, 32'(v));
  endtask
  task automatic ret();
    return_from_interrupt_req <= 1'b1;
    @(posedge clk_i);
    return_from_interrupt_req <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_i, rst_nmi_pin_i, wb_sel_i} = 6'h33;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {supply_supervisor_low_i, global_irq_enable, return_from_interrupt_req, pucsrc, nsrc} = '0;
    {irq_req_i, saw_por, saw_puc, last_taken} = '0;
    repeat (2) @(posedge clk_i);
    chk(por_o, 1);
    rst_i <= 1'b0;
    wait_load(16'hFFFE);
    chk(status_wd_o, 0);
    wb(0, sysrst_pkg::ADR_WDCTL, 0);
    chk(q, 0);
    wb(0, 8'h20, 0);
    chk(q, 0);
    $display("test reset done");
    wb(1, sysrst_pkg::ADR_IRQEN, 32'h0428);
    irq_req_i <= 14'h00A8;
    repeat (12) @(posedge clk_i);
    chk(busy_o, 0);
    global_irq_enable <= 1'b1;
    wait_load(16'hFFEA);
    chk(status_wd_o, 32'h0040);
    chk(last_taken, 32'h0020);
    irq_req_i <= 14'h0088;
    ret();
    wait_load(16'hFFE6);
    irq_req_i <= '0;
    global_irq_enable <= 1'b0;
    ret();
    $display("test maskable done");
    for (int i = 1; i <= 2; i++) begin
      nsrc <= 2'(1 << (i - 1));
      @(posedge clk_i);
      nsrc <= 2'h0;
      wb(0, sysrst_pkg::ADR_FLAGS, 0);
      chk(q, 32'(1 << i));
      chk(busy_o, 0);
      wb(1, sysrst_pkg::ADR_NMIEN, 32'(1 << i));
      wait_load(16'hFFFC);
      wb(0, sysrst_pkg::ADR_NMIEN, 0);
      chk(q, 0);
      wb(1, sysrst_pkg::ADR_FLAGS, 32'(1 << i));
      ret();
    end
    wb(1, sysrst_pkg::ADR_WDCTL, 3);
    wb(1, sysrst_pkg::ADR_NMIEN, 1);
    rst_nmi_pin_i <= 1'b0;
    wait_load(16'hFFFC);
    chk(por_o, 0);
    rst_nmi_pin_i <= 1'b1;
    wb(1, sysrst_pkg::ADR_FLAGS, 1);
    ret();
    $display("test nmi done");
    for (int i = 0; i < 3; i++) begin
      wb(1, sysrst_pkg::ADR_WDCTL, 1);
      {saw_por, saw_puc} <= 2'b00;
      pucsrc <= 3'(1 << i);
      @(posedge clk_i);
      pucsrc <= 3'h0;
      wait_load(16'hFFFE);
      chk({saw_por, saw_puc}, 2'b01);
      wb(0, sysrst_pkg::ADR_WDCTL, 0);
      chk(q, 0);
    end
    for (int j = 0; j < 2; j++) begin
      wb(1, sysrst_pkg::ADR_WDCTL, j * 8);
      saw_por <= 1'b0;
      supply_supervisor_low_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      supply_supervisor_low_i <= 1'b0;
      chk(saw_por, j);
      repeat (10) @(posedge clk_i);
    end
    saw_por <= 1'b0;
    rst_nmi_pin_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_nmi_pin_i <= 1'b1;
    chk(saw_por, 1);
    wait_load(16'hFFFE);
    $display("test resets done");
    print_verdict();
  end
endmodule
`default_nettype wire
